/* usart_data_buffer_status.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE_01: one data address, writes transmit, reads receive
// RULE_02: short characters: tx ignores, rx zeroes upper
// RULE_03: data write dropped while buffer not empty
// RULE_04: buffer loads shifter when empty, shifts out
// RULE_05: two-entry receive FIFO popped by each read
// RULE_06: software avoids read-modify-write on data
// RULE_07: data register eight bits, resets zero
// RULE_08: status: receive, transmit, empty, three errors, modes
// RULE_09: status access mix; only buffer empty resets one
// RULE_10: divisor zero gives clock/16 or clock/8
// RULE_11: receive complete follows FIFO; disable flushes
// RULE_12: transmit complete sets at idle; write-one clears
// RULE_13: double speed oversamples by eight not sixteen
// RULE_14: overrun when full, held char, new start
// RULE_15: error flags travel with each FIFO entry
module usart_data_buffer_status #(
    parameter int INSTANCE   = 0,
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    input  wire logic        receive_pin,
    output logic             transmit_pin
);
    localparam logic [9:0] BASE = 10'(INSTANCE) * usart_pkg::INSTANCE_STRIDE;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    function automatic logic hit(input logic [9:0] idx);
        hit = (address[11:2] == idx + BASE);
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    logic [31:0] readdata_reg, readdata_next;
    logic        wait_reg, wait_next;
    logic        irq_reg, irq_next;
    logic [1:0]  stat_ctl_reg, stat_ctl_next;
    logic [7:0]  control_reg, control_next;
    logic [11:0] baud_reg, baud_next;
    logic [2:0]  irq_mask_reg, irq_mask_next;
    logic [2:0]  irq_stat_reg, irq_stat_next;
    logic [11:0] pre_reg, pre_next;
    logic        accept, data_wr, data_rd, status_wr;
    logic        tick, tx_en, rx_en, par_en, par_odd;
    logic [1:0]  size;
    logic [4:0]  osr;
    logic        rx_push, txc_set, err_set;
    logic        fifo_ne, fifo_full;
    usart_pkg::rx_entry_s head;

    assign readdata    = readdata_reg;
    assign waitrequest = wait_reg;
    assign irq         = irq_reg;
    assign accept      = (read ^ write) && wait_reg;

    // access strobes; a process so that address changes inside hit() are seen
    always_comb begin
        data_wr   = accept && write && byteenable[0] && hit(usart_pkg::DATA_IDX); // RULE_01
        data_rd   = accept && read && hit(usart_pkg::DATA_IDX); // RULE_01
        status_wr = accept && write && byteenable[0] && hit(usart_pkg::STATUS_IDX);
    end

    assign tx_en       = control_reg[usart_pkg::CTL_TX_EN];
    assign rx_en       = control_reg[usart_pkg::CTL_RX_EN];
    assign size        = control_reg[usart_pkg::CTL_SIZE_LSB +: 2];
    assign par_en      = control_reg[usart_pkg::CTL_PARITY_LSB + 1];
    assign par_odd     = control_reg[usart_pkg::CTL_PARITY_LSB];
    assign osr         = stat_ctl_reg[usart_pkg::ST_FAST] ? usart_pkg::OSR_DOUBLE : usart_pkg::OSR_NORMAL; // RULE_13

    // ************************************************************
    // transmitter declarations
    // ************************************************************
    usart_pkg::line_state_e tx_state_reg, tx_state_next;
    logic [7:0] tx_buf_reg, tx_buf_next;
    logic       tx_full_reg, tx_full_next;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic       tx_par_reg, tx_par_next;
    logic [4:0] tx_cnt_reg, tx_cnt_next;
    logic [2:0] tx_bit_reg, tx_bit_next;
    logic       txc_reg, txc_next;
    logic       pin_reg, pin_next;
    logic       tx_last;

    // ************************************************************
    // receiver declarations
    // ************************************************************
    usart_pkg::line_state_e rx_state_reg, rx_state_next;
    logic [4:0] rx_cnt_reg, rx_cnt_next;
    logic [2:0] rx_bit_reg, rx_bit_next;
    logic [7:0] rx_data_reg, rx_data_next;
    logic       rx_par_reg, rx_par_next;
    logic       hold_valid_reg, hold_valid_next;
    usart_pkg::rx_entry_s hold_reg, hold_next;
    logic       rx_last;

    assign transmit_pin = pin_reg;

    // ************************************************************
    // bus slave, registers and interrupt
    // ************************************************************
    always_comb begin
        readdata_next = readdata_reg;
        wait_next     = 1'b1;
        stat_ctl_next = stat_ctl_reg;
        control_next  = control_reg;
        baud_next     = baud_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        if (accept) begin
            wait_next     = 1'b0;
            readdata_next = 32'h0000_0000;
            if (read) begin
                if (hit(usart_pkg::DATA_IDX)) begin
                    readdata_next[7:0] = head.data; // RULE_05
                end else if (hit(usart_pkg::STATUS_IDX)) begin
                    readdata_next[7:0] = {fifo_ne, txc_reg, !tx_full_reg, head.frame_error,
                                          head.overrun, head.parity_error, stat_ctl_reg}; // RULE_08
                end else if (hit(usart_pkg::CONTROL_IDX)) begin
                    readdata_next[7:0] = control_reg;
                end else if (hit(usart_pkg::BAUD_IDX)) begin
                    readdata_next[11:0] = baud_reg;
                end else if (hit(usart_pkg::IRQ_MASK_IDX)) begin
                    readdata_next[2:0] = irq_mask_reg;
                end else if (hit(usart_pkg::IRQ_STATUS_IDX)) begin
                    readdata_next[2:0] = irq_stat_reg;
                    irq_stat_next      = 3'h0; // read clears
                end
            end else if (byteenable[0]) begin
                if (status_wr) begin
                    stat_ctl_next = writedata[1:0]; // RULE_09
                end else if (hit(usart_pkg::CONTROL_IDX)) begin
                    control_next = writedata[7:0];
                end else if (hit(usart_pkg::IRQ_MASK_IDX)) begin
                    irq_mask_next = writedata[2:0];
                end else if (hit(usart_pkg::BAUD_IDX)) begin
                    baud_next[7:0] = writedata[7:0];
                end
                if (hit(usart_pkg::BAUD_IDX) && byteenable[1]) begin
                    baud_next[11:8] = writedata[11:8];
                end
            end
        end
        // events set after the read clear so a set always wins
        irq_stat_next = irq_stat_next | {err_set, txc_set, rx_push};
        irq_next      = |(irq_stat_reg & irq_mask_reg);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_reg <= 32'h0000_0000;
            wait_reg     <= 1'b1;
            irq_reg      <= 1'b0;
            stat_ctl_reg <= usart_pkg::STATUS_RESET; // RULE_09
            control_reg  <= usart_pkg::CONTROL_RESET;
            baud_reg     <= usart_pkg::BAUD_RESET;
            irq_mask_reg <= usart_pkg::IRQ_RESET;
            irq_stat_reg <= usart_pkg::IRQ_RESET;
        end else begin
            readdata_reg <= readdata_next;
            wait_reg     <= wait_next;
            irq_reg      <= irq_next;
            stat_ctl_reg <= stat_ctl_next;
            control_reg  <= control_next;
            baud_reg     <= baud_next;
            irq_mask_reg <= irq_mask_next;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // ************************************************************
    // baud prescaler: one tick every divisor+1 clocks
    // ************************************************************
    assign tick = (pre_reg == 12'h000); // RULE_10

    always_comb begin
        pre_next = tick ? baud_reg : pre_reg - 12'h001;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= usart_pkg::BAUD_RESET;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // ************************************************************
    // transmitter: buffer, shifter, line pin
    // ************************************************************
    assign tx_last = tick && (tx_cnt_reg == osr - 5'h01);

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_buf_next   = tx_buf_reg;
        tx_full_next  = tx_full_reg;
        tx_shift_next = tx_shift_reg;
        tx_par_next   = tx_par_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_bit_next   = tx_bit_reg;
        txc_next      = txc_reg;
        pin_next      = 1'b1;
        txc_set       = 1'b0;
        if (data_wr && !tx_full_reg) begin // RULE_03
            tx_buf_next  = writedata[7:0]; // RULE_07
            tx_full_next = 1'b1;
        end
        if (tx_state_reg != usart_pkg::LINE_IDLE && tick) begin
            tx_cnt_next = tx_last ? 5'h00 : tx_cnt_reg + 5'h01;
        end
        unique case (tx_state_reg)
            usart_pkg::LINE_IDLE: begin
                if (tx_full_reg && tx_en) begin // RULE_04
                    tx_shift_next = usart_pkg::mask_char(tx_buf_reg, size); // RULE_02
                    tx_par_next   = usart_pkg::parity_bit(tx_buf_reg, size, par_odd);
                    tx_full_next  = 1'b0;
                    tx_cnt_next   = 5'h00;
                    tx_state_next = usart_pkg::LINE_START;
                end
            end
            usart_pkg::LINE_START: begin
                pin_next = 1'b0;
                if (tx_last) begin
                    tx_bit_next   = 3'h0;
                    tx_state_next = usart_pkg::LINE_DATA;
                end
            end
            usart_pkg::LINE_DATA: begin
                pin_next = tx_shift_reg[0];
                if (tx_last) begin
                    tx_shift_next = tx_shift_reg >> 1;
                    tx_bit_next   = tx_bit_reg + 3'h1;
                    if (tx_bit_reg == 3'h4 + 3'(size)) begin
                        tx_state_next = par_en ? usart_pkg::LINE_PARITY : usart_pkg::LINE_STOP;
                    end
                end
            end
            usart_pkg::LINE_PARITY: begin
                pin_next = tx_par_reg;
                if (tx_last) begin
                    tx_state_next = usart_pkg::LINE_STOP;
                end
            end
            usart_pkg::LINE_STOP: begin
                if (tx_last) begin
                    tx_state_next = usart_pkg::LINE_IDLE;
                    txc_set       = !tx_full_reg; // RULE_12
                end
            end
            default: begin
                tx_state_next = usart_pkg::LINE_IDLE;
            end
        endcase
        if (status_wr && writedata[usart_pkg::ST_TX_DONE]) begin
            txc_next = 1'b0; // RULE_12
        end
        if (txc_set) begin
            txc_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= usart_pkg::LINE_IDLE;
            tx_buf_reg   <= usart_pkg::DATA_RESET; // RULE_07
            tx_full_reg  <= 1'b0;                  // buffer empty reads one
            tx_shift_reg <= 8'h00;
            tx_par_reg   <= 1'b0;
            tx_cnt_reg   <= 5'h00;
            tx_bit_reg   <= 3'h0;
            txc_reg      <= 1'b0;
            pin_reg      <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_buf_reg   <= tx_buf_next;
            tx_full_reg  <= tx_full_next;
            tx_shift_reg <= tx_shift_next;
            tx_par_reg   <= tx_par_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_bit_reg   <= tx_bit_next;
            txc_reg      <= txc_next;
            pin_reg      <= pin_next;
        end
    end

    // ************************************************************
    // receiver: mid-bit sampling, holding slot, overrun
    // ************************************************************
    assign rx_last = tick && (rx_cnt_reg == osr - 5'h01);

    always_comb begin
        rx_state_next   = rx_state_reg;
        rx_cnt_next     = rx_cnt_reg;
        rx_bit_next     = rx_bit_reg;
        rx_data_next    = rx_data_reg;
        rx_par_next     = rx_par_reg;
        hold_valid_next = hold_valid_reg;
        hold_next       = hold_reg;
        rx_push         = hold_valid_reg && !fifo_full;
        err_set         = rx_push && (hold_reg.frame_error || hold_reg.overrun || hold_reg.parity_error);
        if (rx_push) begin
            hold_valid_next = 1'b0;
        end
        if (rx_state_reg != usart_pkg::LINE_IDLE && tick) begin
            rx_cnt_next = rx_last ? 5'h00 : rx_cnt_reg + 5'h01;
        end
        unique case (rx_state_reg)
            usart_pkg::LINE_IDLE: begin
                if (!receive_pin) begin
                    rx_cnt_next   = 5'h00;
                    rx_state_next = usart_pkg::LINE_START;
                    if (hold_valid_reg && fifo_full) begin
                        hold_next.overrun = 1'b1; // RULE_14
                    end
                end
            end
            usart_pkg::LINE_START: begin
                if (tick && rx_cnt_reg == (osr >> 1) - 5'h01) begin
                    rx_cnt_next   = 5'h00;
                    rx_bit_next   = 3'h0;
                    rx_data_next  = 8'h00; // RULE_02
                    rx_state_next = receive_pin ? usart_pkg::LINE_IDLE : usart_pkg::LINE_DATA;
                end
            end
            usart_pkg::LINE_DATA: begin
                if (rx_last) begin
                    rx_data_next[rx_bit_reg] = receive_pin;
                    rx_bit_next              = rx_bit_reg + 3'h1;
                    if (rx_bit_reg == 3'h4 + 3'(size)) begin
                        rx_state_next = par_en ? usart_pkg::LINE_PARITY : usart_pkg::LINE_STOP;
                    end
                end
            end
            usart_pkg::LINE_PARITY: begin
                if (rx_last) begin
                    rx_par_next   = receive_pin;
                    rx_state_next = usart_pkg::LINE_STOP;
                end
            end
            usart_pkg::LINE_STOP: begin
                if (rx_last) begin
                    rx_state_next = usart_pkg::LINE_IDLE;
                    if (!hold_valid_next) begin // a frame arriving on a full path is lost
                        hold_valid_next        = 1'b1;
                        hold_next.data         = rx_data_reg;
                        hold_next.frame_error  = !receive_pin; // RULE_15
                        hold_next.overrun      = 1'b0;
                        hold_next.parity_error = par_en &&
                            (rx_par_reg != usart_pkg::parity_bit(rx_data_reg, size, par_odd)); // RULE_15
                    end
                end
            end
            default: begin
                rx_state_next = usart_pkg::LINE_IDLE;
            end
        endcase
        if (!rx_en) begin
            rx_state_next   = usart_pkg::LINE_IDLE; // RULE_11
            hold_valid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg   <= usart_pkg::LINE_IDLE;
            rx_cnt_reg     <= 5'h00;
            rx_bit_reg     <= 3'h0;
            rx_data_reg    <= 8'h00;
            rx_par_reg     <= 1'b0;
            hold_valid_reg <= 1'b0;
            hold_reg       <= '0;
        end else begin
            rx_state_reg   <= rx_state_next;
            rx_cnt_reg     <= rx_cnt_next;
            rx_bit_reg     <= rx_bit_next;
            rx_data_reg    <= rx_data_next;
            rx_par_reg     <= rx_par_next;
            hold_valid_reg <= hold_valid_next;
            hold_reg       <= hold_next;
        end
    end

    // ************************************************************
    // receive FIFO with per-entry error flags
    // ************************************************************
    rx_fifo #(
        .DEPTH (FIFO_DEPTH)
    ) i_rx_fifo (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .flush      (!rx_en),  // RULE_11
        .push       (rx_push),
        .push_entry (hold_reg),
        .pop        (data_rd), // RULE_05
        .head       (head),
        .not_empty  (fifo_ne),
        .full       (fifo_full)
    );

endmodule

/* usart_pkg.sv */
package usart_pkg;

    // ************************************************************
    // register indexes (byte address is four times the index)
    // ************************************************************
    localparam logic [9:0] STATUS_IDX      = 10'h0C0;
    localparam logic [9:0] CONTROL_IDX     = 10'h0C1;
    localparam logic [9:0] IRQ_STATUS_IDX  = 10'h0C3;
    localparam logic [9:0] BAUD_IDX        = 10'h0C4;
    localparam logic [9:0] IRQ_MASK_IDX    = 10'h0C5;
    localparam logic [9:0] DATA_IDX        = 10'h0C6;
    localparam logic [9:0] INSTANCE_STRIDE = 10'h008;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ST_RX_READY   = 7;
    localparam int ST_TX_DONE    = 6;
    localparam int ST_TX_EMPTY   = 5;
    localparam int ST_FRAME_ERR  = 4;
    localparam int ST_LOST       = 3;
    localparam int ST_PARITY_ERR = 2;
    localparam int ST_FAST       = 1;
    localparam int ST_MULTI      = 0;
    localparam int CTL_SIZE_LSB   = 0;
    localparam int CTL_TX_EN      = 3;
    localparam int CTL_RX_EN      = 4;
    localparam int CTL_PARITY_LSB = 5;
    localparam int IRQ_RX  = 0;
    localparam int IRQ_TX  = 1;
    localparam int IRQ_ERR = 2;

    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [7:0]  DATA_RESET    = 8'h00;
    localparam logic [1:0]  STATUS_RESET  = 2'h0;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [11:0] BAUD_RESET    = 12'h000;
    localparam logic [2:0]  IRQ_RESET     = 3'h0;
    localparam logic [4:0]  OSR_NORMAL    = 5'h10;
    localparam logic [4:0]  OSR_DOUBLE    = 5'h08;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [7:0] data;
        logic       frame_error;
        logic       overrun;
        logic       parity_error;
    } rx_entry_s;

    typedef enum logic [2:0] {
        LINE_IDLE   = 3'b000,
        LINE_START  = 3'b001,
        LINE_DATA   = 3'b010,
        LINE_PARITY = 3'b011,
        LINE_STOP   = 3'b100
    } line_state_e;

    // ************************************************************
    // helpers
    // ************************************************************
    // keep only the bits of a 5..8 bit character
    function automatic logic [7:0] mask_char(input logic [7:0] d, input logic [1:0] size);
        mask_char = d & (8'hFF >> (2'h3 - size));
    endfunction

    function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] size, input logic odd);
        parity_bit = (^mask_char(d, size)) ^ odd;
    endfunction

endpackage

/* rx_fifo.sv */
`timescale 1ns/1ps
module rx_fifo #(
    parameter int DEPTH = 2
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 flush,
    input  wire logic                 push,
    input  wire usart_pkg::rx_entry_s push_entry,
    input  wire logic                 pop,
    output usart_pkg::rx_entry_s      head,
    output logic                      not_empty,
    output logic                      full
);
    localparam int PW = $clog2(DEPTH);

    usart_pkg::rx_entry_s mem_reg [DEPTH];
    usart_pkg::rx_entry_s mem_next [DEPTH];
    logic [PW:0]          count_reg;
    logic [PW:0]          count_next;
    logic [PW-1:0]        rd_reg;
    logic [PW-1:0]        rd_next;
    logic [PW-1:0]        wr_idx;

    assign not_empty = (count_reg != '0);
    assign full      = (count_reg == (PW+1)'(DEPTH));
    assign head      = not_empty ? mem_reg[rd_reg] : '0;

    // ************************************************************
    // pointer and storage update
    // ************************************************************
    always_comb begin
        mem_next   = mem_reg;
        count_next = count_reg;
        rd_next    = rd_reg;
        wr_idx     = PW'((rd_reg + count_reg[PW-1:0]) % DEPTH);
        if (flush) begin
            count_next = '0;
        end else begin
            if (pop && not_empty) begin
                rd_next    = PW'((rd_reg + 1'b1) % DEPTH);
                count_next = count_next - 1'b1;
            end
            if (push && !full) begin
                mem_next[wr_idx] = push_entry;
                count_next       = count_next + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            count_reg <= '0;
            rd_reg    <= '0;
        end else begin
            mem_reg   <= mem_next;
            count_reg <= count_next;
            rd_reg    <= rd_next;
        end
    end

endmodule

/* usart_checker_sva.sv */
`timescale 1ns/1ps
module usart_checker (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [11:0] address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        irq,
    input wire logic        transmit_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // bus request taken, and a read of one index
    sequence s_take; (read ^ write) && waitrequest; endsequence
    sequence s_rd(logic [9:0] i); read && waitrequest && address[11:2] == i; endsequence
    AST_ANSWER: assert property (s_take |=> !waitrequest) else $error("no answer");
    AST_PULSE: assert property (!waitrequest |=> waitrequest) else $error("long answer");
    AST_UPPER: assert property (!waitrequest |-> readdata[31:12] == 20'h0 && (readdata[11:8] == 4'h0 ||
        address[11:2] == 10'h0C4)) else $error("upper bits");
    AST_HOLD: assert property (waitrequest && !(read ^ write) |=> $stable(readdata)) else $error("data moved");
    AST_UNMAP: assert property (s_rd(10'h0C2) |=> readdata == 32'h0) else $error("unmapped");
    AST_START: assert property ($fell(transmit_pin) |-> !transmit_pin [*8]) else $error("start");
    AST_BIT: assert property ($changed(transmit_pin) |=> $stable(transmit_pin) [*7]) else $error("bit");
    AST_IRQ_CLR: assert property (s_rd(10'h0C3) |-> ##3 !irq) else $error("irq kept");
endmodule
bind usart_data_buffer_status usart_checker i_usart_checker (.core_clk(core_clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .transmit_pin(transmit_pin));

/* line_echo.sv */
`timescale 1ns/1ps
module line_echo #(
    parameter int LAG = 3
) (
    input  wire logic core_clk,
    output logic      receive_pin,
    input  wire logic transmit_pin
);
    logic [LAG-1:0] line_reg = '1;
    // far end sends every frame back after a short line delay
    always @(posedge core_clk) line_reg <= {line_reg[LAG-2:0], transmit_pin};
    assign receive_pin = line_reg[LAG-1];
endmodule

/* usart_data_buffer_status_test.sv */
`timescale 1ns/1ps
module usart_data_buffer_status_test;
    logic        core_clk = 0;
    logic        rst_b = 0;
    logic [11:0] address = 0;
    logic        read = 0;
    logic        write = 0;
    logic [31:0] writedata = 0;
    logic [31:0] readdata;
    logic        waitrequest, irq, receive_pin, transmit_pin;
    logic [7:0]  q;
    int          miscompares = 0;
    int          num_checks = 0;
    always #50 core_clk = ~core_clk;
    usart_data_buffer_status i_usart_data_buffer_status (.core_clk(core_clk), .rst_b(rst_b),
        .address(address), .read(read), .write(write), .byteenable(4'h1), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .receive_pin(receive_pin),
        .transmit_pin(transmit_pin));
    line_echo i_line_echo (.core_clk(core_clk), .receive_pin(receive_pin), .transmit_pin(transmit_pin));
    // one bus access, held until waitrequest is sampled low; never a read-modify-write
    task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= {24'h0, d};
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task t_reset;
        rdc(12'h300, 8'h20);
        rdc(12'h318, 8'h00);
        rdc(12'h308, 8'h00);
        $display("t_reset done");
    endtask
    // third byte meets a full buffer and is lost
    task t_loop;
        acc(1'b1, 12'h304, 8'h1B);
        acc(1'b1, 12'h314, 8'h01);
        acc(1'b1, 12'h318, 8'hA5);
        acc(1'b1, 12'h318, 8'hB6);
        acc(1'b1, 12'h318, 8'hC7);
        repeat (400) @(posedge core_clk);
        chk({7'h0, irq}, 8'h01);
        rdc(12'h300, 8'hE0);
        rdc(12'h318, 8'hA5);
        rdc(12'h318, 8'hB6);
        rdc(12'h300, 8'h60);
        acc(1'b1, 12'h300, 8'h40);
        rdc(12'h300, 8'h20);
        acc(1'b0, 12'h30C, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({7'h0, irq}, 8'h00);
        $display("t_loop done");
    endtask
    task t_short;
        acc(1'b1, 12'h304, 8'h58);
        acc(1'b1, 12'h300, 8'h02);
        rdc(12'h300, 8'h22);
        acc(1'b1, 12'h318, 8'hFF);
        repeat (100) @(posedge core_clk);
        rdc(12'h300, 8'hE2);
        rdc(12'h318, 8'h1F);
        $display("t_short done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset;
        t_loop;
        t_short;
        results;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge core_clk);
        miscompares++;
        results;
    end
endmodule
